// ===== logic/ltg_cfg.svh
/*
 * Constants of the LPDDR3 command-timing guard: APB map, field slices,
 * reset values and time figures with their cycle conversions.
 * Assumes a 200 MHz command clock.
 */
`ifndef LTG_CFG_SVH
`define LTG_CFG_SVH

`define LTG_CLK_PS 5000
// round up to whole cycles, never below one
`define LTG_NS2CYC(ns) ((((ns) * 1000 + `LTG_CLK_PS - 1) / `LTG_CLK_PS) < 1 ? 1 : \
    (((ns) * 1000 + `LTG_CLK_PS - 1) / `LTG_CLK_PS))

// ===========================================================
// time figures
`define LTG_INIT_US 500
`define LTG_INIT_CYC ((`LTG_INIT_US * 1000 * 1000 + `LTG_CLK_PS - 1) / `LTG_CLK_PS)
`define LTG_RCD_NS 18
`define LTG_RAS_NS 42
`define LTG_RP_NS 18
`define LTG_WR_NS 15
`define LTG_FAW_NS 50
`define LTG_RFC_NS 130
`define LTG_REFI_NS 3900
`define LTG_RRD_CYC 2
`define LTG_WTR_CYC 4
`define LTG_RTP_CYC 4
`define LTG_MRR_CYC 4
`define LTG_MRW_CYC 10
`define LTG_WBURST_CYC 6

// ===========================================================
// register byte offsets
`define LTG_OFS_CTRL 8'h00
`define LTG_OFS_STATUS 8'h04
`define LTG_OFS_T_ACT 8'h08
`define LTG_OFS_T_RW 8'h0C
`define LTG_OFS_T_MISC 8'h10
`define LTG_OFS_T_REF 8'h14

// ===========================================================
// field slices
`define LTG_F_START 0
`define LTG_F_CKE 0
`define LTG_F_INITD 1
`define LTG_F_RDUE 2
`define LTG_F_DEBT 11:8
`define LTG_F_RCD 7:0
`define LTG_F_RAS 15:8
`define LTG_F_RP 23:16
`define LTG_F_RRD 31:24
`define LTG_F_WR 7:0
`define LTG_F_WTR 15:8
`define LTG_F_RTP 23:16
`define LTG_F_FAW 31:24
`define LTG_F_MRR 7:0
`define LTG_F_MRW 15:8
`define LTG_F_WBURST 23:16
`define LTG_F_RFC 15:0
`define LTG_F_REFI 31:16

// ===========================================================
// reset values
`define LTG_RST_T_ACT {8'(`LTG_RRD_CYC), 8'(`LTG_NS2CYC(`LTG_RP_NS)), \
    8'(`LTG_NS2CYC(`LTG_RAS_NS)), 8'(`LTG_NS2CYC(`LTG_RCD_NS))}
`define LTG_RST_T_RW {8'(`LTG_NS2CYC(`LTG_FAW_NS)), 8'(`LTG_RTP_CYC), \
    8'(`LTG_WTR_CYC), 8'(`LTG_NS2CYC(`LTG_WR_NS))}
`define LTG_RST_T_MISC {8'h00, 8'(`LTG_WBURST_CYC), 8'(`LTG_MRW_CYC), 8'(`LTG_MRR_CYC)}
`define LTG_RST_T_REF {16'(`LTG_NS2CYC(`LTG_REFI_NS)), 16'(`LTG_NS2CYC(`LTG_RFC_NS))}
`define LTG_DEBT_MAX 4'h8

`endif

// ===== logic/ltg_pkg.sv
/*
 * Types of the LPDDR3 command-timing guard.
 * Assumes nothing beyond the constants header.
 */
package ltg_pkg;
    // ===========================================================
    // command opcodes, one-hot
    typedef enum logic [7:0] {
        OP_NOP = 8'h01,
        OP_ACT = 8'h02,
        OP_RD = 8'h04,
        OP_WR = 8'h08,
        OP_PRE = 8'h10,
        OP_REF = 8'h20,
        OP_MRR = 8'h40,
        OP_MRW = 8'h80
    } ltg_op_e;

    typedef enum logic [2:0] {
        ST_HOLD = 3'h1,
        ST_WAIT = 3'h2,
        ST_RUN = 3'h4
    } ltg_state_e;

    typedef struct packed {
        logic valid;
        ltg_op_e op;
        logic [2:0] bank;
    } ltg_cmd_s;
endpackage

// ===== logic/ltg_timer.sv
/*
 * Down-counter that stays busy for one cycle fewer than the loaded number.
 * Assumes the loader asserts load in the cycle a command is accepted.
 */
`timescale 1ns/1ps
`default_nettype none
module ltg_timer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [15:0] value,
    output logic busy
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [15:0] dec;
    logic [15:0] want;

    // a new load never shortens a spacing already running
    always_comb begin
        dec = (cnt == 16'h0000) ? 16'h0000 : cnt - 16'h0001;
        want = (value == 16'h0000) ? 16'h0000 : value - 16'h0001;
        next_cnt = (load && want > dec) ? want : dec;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign busy = (cnt != 16'h0000);
endmodule
`default_nettype wire

// ===== logic/ltg_guard.sv
/*
 * LPDDR3 command-timing guard: power-up sequencing, per-bank and per-rank
 * spacing checks and refresh bookkeeping, with an APB register file.
 * Assumes the requester holds cmd_req until cmd_issue.valid answers it.
 */
// Function
// - after the memory reset is released, clock enable stays low for 500 us more.
// - no command follows a mode register read sooner than the mode-read spacing.
// - no command follows a mode register write sooner than the mode-write spacing.
// - a bank is not precharged before the activate-to-precharge minimum has passed.
// - a read or write waits the activate-to-access delay after its bank's activate.
// - after a bank precharge, that bank gets no activate, read or write, and no refresh is issued, for the bank precharge period.
// - after a write burst, the bank is not precharged before the write recovery time.
// - two activates are spaced by at least the activate-to-activate gap in cycles.
// - at most four activates fall within any four-activate window.
// - a read to a bank waits the write-to-read turnaround after the last write data.
// - a precharge waits the read-to-precharge gap after a read.
// - after an all-bank refresh, nothing is issued for the refresh cycle time.
// - refreshes are kept so their average gap stays within the refresh interval.
`timescale 1ns/1ps
`default_nettype none
`include "ltg_cfg.svh"
module ltg_guard #(
    parameter int INIT_CYCLES = `LTG_INIT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ltg_pkg::ltg_cmd_s cmd_req,
    output ltg_pkg::ltg_cmd_s cmd_issue,
    output logic mem_reset_n,
    output logic cke,
    output logic refresh_due
);
    import ltg_pkg::*;

    function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        add16 = s[16] ? 16'hFFFF : s[15:0];
    endfunction

    // ===========================================================
    // APB register file
    logic [31:0] ctrl, t_act, t_rw, t_misc, t_ref;
    logic [31:0] next_ctrl, next_t_act, next_t_rw, next_t_misc, next_t_ref;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [3:0] debt;
    ltg_state_e state;
    logic hit;

    always_comb begin
        next_ctrl = ctrl;
        next_t_act = t_act;
        next_t_rw = t_rw;
        next_t_misc = t_misc;
        next_t_ref = t_ref;
        next_prdata = 32'h0000_0000;
        // one wait state: the answer is registered at the first access edge
        next_pready = psel && penable && !pready;
        hit = 1'b1;
        unique case (paddr)
            `LTG_OFS_CTRL: next_prdata = ctrl;
            `LTG_OFS_STATUS: begin
                next_prdata[`LTG_F_CKE] = cke;
                next_prdata[`LTG_F_INITD] = (state == ST_RUN);
                next_prdata[`LTG_F_RDUE] = refresh_due;
                next_prdata[`LTG_F_DEBT] = debt;
            end
            `LTG_OFS_T_ACT: next_prdata = t_act;
            `LTG_OFS_T_RW: next_prdata = t_rw;
            `LTG_OFS_T_MISC: next_prdata = t_misc;
            `LTG_OFS_T_REF: next_prdata = t_ref;
            default: hit = 1'b0;
        endcase
        next_pslverr = next_pready && !hit;
        if (pwrite) begin
            next_prdata = 32'h0000_0000;
        end
        if (psel && penable && pready && pwrite) begin
            unique case (paddr)
                `LTG_OFS_CTRL: next_ctrl = pwdata;
                `LTG_OFS_T_ACT: next_t_act = pwdata;
                `LTG_OFS_T_RW: next_t_rw = pwdata;
                `LTG_OFS_T_MISC: next_t_misc = pwdata;
                `LTG_OFS_T_REF: next_t_ref = pwdata;
                default: next_ctrl = ctrl;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= 32'h0000_0000;
            t_act <= `LTG_RST_T_ACT;
            t_rw <= `LTG_RST_T_RW;
            t_misc <= `LTG_RST_T_MISC;
            t_ref <= `LTG_RST_T_REF;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            t_act <= next_t_act;
            t_rw <= next_t_rw;
            t_misc <= next_t_misc;
            t_ref <= next_t_ref;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ===========================================================
    // power-up sequencing
    ltg_state_e next_state;
    logic [16:0] init_cnt, next_init_cnt;

    always_comb begin
        next_state = state;
        next_init_cnt = init_cnt;
        unique case (state)
            ST_HOLD: begin
                next_init_cnt = 17'(INIT_CYCLES);
                if (ctrl[`LTG_F_START]) begin
                    next_state = ST_WAIT;
                end
            end
            // the memory initialises itself here; nothing is offered to it
            ST_WAIT: begin
                next_init_cnt = init_cnt - 17'h00001;
                if (init_cnt == 17'h00001) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: next_state = ST_RUN;
            default: next_state = ST_HOLD;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_HOLD;
            init_cnt <= 17'h00000;
            mem_reset_n <= 1'b0;
            cke <= 1'b0;
        end else begin
            state <= next_state;
            init_cnt <= next_init_cnt;
            mem_reset_n <= (next_state != ST_HOLD);
            cke <= (next_state == ST_RUN);
        end
    end

    // ===========================================================
    // spacing counters
    logic accept;
    logic [7:0] is_bank;
    logic [7:0] rcd_busy, ras_busy, rp_busy, wr_busy, wtr_busy;
    logic [3:0] faw_busy;
    logic [1:0] faw_ptr, next_faw_ptr;
    logic rrd_busy, rtp_busy, gap_busy;
    logic [15:0] gap_val, wburst;
    logic op_act, op_rd, op_wr, op_pre;

    assign wburst = 16'(t_misc[`LTG_F_WBURST]);
    assign op_act = accept && cmd_req.op == OP_ACT;
    assign op_rd = accept && cmd_req.op == OP_RD;
    assign op_wr = accept && cmd_req.op == OP_WR;
    assign op_pre = accept && cmd_req.op == OP_PRE;

    // per-bank spacing, one counter per limit and bank
    for (genvar b = 0; b < 8; b++) begin : g_bank
        assign is_bank[b] = (cmd_req.bank == 3'(b));
        ltg_timer u_rcd (.clk_sys(clk_sys), .rst(rst), .load(op_act && is_bank[b]),
            .value(16'(t_act[`LTG_F_RCD])), .busy(rcd_busy[b]));
        ltg_timer u_ras (.clk_sys(clk_sys), .rst(rst), .load(op_act && is_bank[b]),
            .value(16'(t_act[`LTG_F_RAS])), .busy(ras_busy[b]));
        ltg_timer u_rp (.clk_sys(clk_sys), .rst(rst), .load(op_pre && is_bank[b]),
            .value(16'(t_act[`LTG_F_RP])), .busy(rp_busy[b]));
        // both write limits run from the end of the burst, not the command
        ltg_timer u_wr (.clk_sys(clk_sys), .rst(rst), .load(op_wr && is_bank[b]),
            .value(add16(16'(t_rw[`LTG_F_WR]), wburst)), .busy(wr_busy[b]));
        ltg_timer u_wtr (.clk_sys(clk_sys), .rst(rst), .load(op_wr && is_bank[b]),
            .value(add16(16'(t_rw[`LTG_F_WTR]), wburst)), .busy(wtr_busy[b]));
    end

    // rolling window: the oldest of four slots must have expired
    for (genvar f = 0; f < 4; f++) begin : g_faw
        ltg_timer u_faw (.clk_sys(clk_sys), .rst(rst), .load(op_act && faw_ptr == 2'(f)),
            .value(16'(t_rw[`LTG_F_FAW])), .busy(faw_busy[f]));
    end
    assign next_faw_ptr = op_act ? faw_ptr + 2'h1 : faw_ptr;

    ltg_timer u_rrd (.clk_sys(clk_sys), .rst(rst), .load(op_act),
        .value(16'(t_act[`LTG_F_RRD])), .busy(rrd_busy));
    ltg_timer u_rtp (.clk_sys(clk_sys), .rst(rst), .load(op_rd),
        .value(16'(t_rw[`LTG_F_RTP])), .busy(rtp_busy));

    // a single rank-wide gap covers mode register and refresh spacing
    always_comb begin
        unique case (cmd_req.op)
            OP_MRR: gap_val = 16'(t_misc[`LTG_F_MRR]);
            OP_MRW: gap_val = 16'(t_misc[`LTG_F_MRW]);
            OP_REF: gap_val = t_ref[`LTG_F_RFC];
            default: gap_val = 16'h0000;
        endcase
    end
    ltg_timer u_gap (.clk_sys(clk_sys), .rst(rst), .load(accept), .value(gap_val), .busy(gap_busy));

    // ===========================================================
    // issue decision
    logic allowed;
    logic [2:0] bk;
    ltg_cmd_s next_issue;

    always_comb begin
        bk = cmd_req.bank;
        allowed = !gap_busy;
        // owed refreshes at the limit hold back everything but refresh
        if (debt == `LTG_DEBT_MAX && cmd_req.op != OP_REF) begin
            allowed = 1'b0;
        end
        unique case (cmd_req.op)
            OP_ACT: allowed = allowed && !rp_busy[bk] && !rrd_busy && !faw_busy[faw_ptr];
            OP_RD: allowed = allowed && !rp_busy[bk] && !rcd_busy[bk] && !wtr_busy[bk];
            OP_WR: allowed = allowed && !rp_busy[bk] && !rcd_busy[bk];
            OP_PRE: allowed = allowed && !ras_busy[bk] && !wr_busy[bk] && !rtp_busy;
            OP_REF: allowed = allowed && (rp_busy == 8'h00);
            default: allowed = allowed;
        endcase
        // the acknowledge gap stops a held request being taken twice
        accept = (state == ST_RUN) && cmd_req.valid && !cmd_issue.valid && allowed && cmd_req.op != OP_NOP;
        next_issue = cmd_req;
        next_issue.valid = accept;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_issue <= '{valid: 1'b0, op: OP_NOP, bank: 3'h0};
            faw_ptr <= 2'h0;
        end else begin
            cmd_issue <= next_issue;
            faw_ptr <= next_faw_ptr;
        end
    end

    // ===========================================================
    // refresh bookkeeping: a tick and a refresh in one cycle cancel
    logic [15:0] refi_cnt, next_refi_cnt;
    logic [3:0] next_debt;
    logic tick, op_ref;

    assign op_ref = accept && cmd_req.op == OP_REF;
    always_comb begin
        tick = (state == ST_RUN) && (refi_cnt == 16'h0000);
        next_refi_cnt = (state != ST_RUN || tick || refi_cnt >= t_ref[`LTG_F_REFI]) ?
            t_ref[`LTG_F_REFI] - 16'h0001 : refi_cnt - 16'h0001; // a shortened interval applies at once
        next_debt = debt;
        if (tick && !op_ref && debt != `LTG_DEBT_MAX) begin
            next_debt = debt + 4'h1;
        end else if (op_ref && !tick && debt != 4'h0) begin
            next_debt = debt - 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            refi_cnt <= 16'h0000;
            debt <= 4'h0;
            refresh_due <= 1'b0;
        end else begin
            refi_cnt <= next_refi_cnt;
            debt <= next_debt;
            refresh_due <= (next_debt != 4'h0);
        end
    end

    // ===========================================================
    // checks: gaps counted between issue pulses
    logic [15:0] since_last, since_act, since_rd;
    logic [15:0] since_bact [8];
    ltg_op_e last_op;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            since_last <= 16'hFFFF;
            since_act <= 16'hFFFF;
            since_rd <= 16'hFFFF;
            last_op <= OP_NOP;
            for (int i = 0; i < 8; i++) begin
                since_bact[i] <= 16'hFFFF;
            end
        end else begin
            since_last <= cmd_issue.valid ? 16'h0001 : add16(since_last, 16'h0001);
            since_act <= (cmd_issue.valid && cmd_issue.op == OP_ACT) ? 16'h0001 : add16(since_act, 16'h0001);
            since_rd <= (cmd_issue.valid && cmd_issue.op == OP_RD) ? 16'h0001 : add16(since_rd, 16'h0001);
            last_op <= cmd_issue.valid ? cmd_issue.op : last_op;
            for (int i = 0; i < 8; i++) begin
                since_bact[i] <= (cmd_issue.valid && cmd_issue.op == OP_ACT && cmd_issue.bank == 3'(i)) ?
                    16'h0001 : add16(since_bact[i], 16'h0001);
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_CKE_AFTER_WAIT: assert property ($rose(cke) |-> $past(state) == ST_WAIT && $past(init_cnt) == 17'h00001)
        else $error("clock enable rose before the init wait ended");
    AST_MRR_GAP: assert property (cmd_issue.valid && last_op == OP_MRR |-> since_last >= 16'(t_misc[`LTG_F_MRR]))
        else $error("command too soon after mode read");
    AST_MRW_GAP: assert property (cmd_issue.valid && last_op == OP_MRW |-> since_last >= 16'(t_misc[`LTG_F_MRW]))
        else $error("command too soon after mode write");
    AST_RAS_MIN: assert property (cmd_issue.valid && cmd_issue.op == OP_PRE
        |-> since_bact[cmd_issue.bank] >= 16'(t_act[`LTG_F_RAS]))
        else $error("precharge before activate-to-precharge minimum");
    AST_RCD_MIN: assert property (cmd_issue.valid && (cmd_issue.op == OP_RD || cmd_issue.op == OP_WR)
        |-> since_bact[cmd_issue.bank] >= 16'(t_act[`LTG_F_RCD]))
        else $error("column command before activate-to-access delay");
    AST_RRD_MIN: assert property (cmd_issue.valid && cmd_issue.op == OP_ACT |-> since_act >= 16'(t_act[`LTG_F_RRD]))
        else $error("activates too close together");
    AST_RTP_MIN: assert property (cmd_issue.valid && cmd_issue.op == OP_PRE |-> since_rd >= 16'(t_rw[`LTG_F_RTP]))
        else $error("precharge too soon after read");
    AST_RFC_GAP: assert property (cmd_issue.valid && last_op == OP_REF |-> since_last >= t_ref[`LTG_F_RFC])
        else $error("command inside refresh cycle time");
    AST_DEBT_HOLD: assert property (debt == `LTG_DEBT_MAX && !(cmd_req.op == OP_REF)
        |=> !cmd_issue.valid)
        else $error("command issued with refresh debt at limit");
    AST_RUN_ONLY: assert property (cmd_issue.valid |-> cke ##1 !cmd_issue.valid)
        else $error("issue outside run or back to back");

    COV_ACT_RD: cover property (cmd_issue.valid && cmd_issue.op == OP_ACT ##[1:40] cmd_issue.valid && cmd_issue.op == OP_RD);
    COV_WR_PRE: cover property (cmd_issue.valid && cmd_issue.op == OP_WR ##[1:80] cmd_issue.valid && cmd_issue.op == OP_PRE);
    COV_REF: cover property (cmd_issue.valid && cmd_issue.op == OP_REF);
    COV_FAW_FULL: cover property (op_act ##1 faw_busy == 4'hF);
endmodule
`default_nettype wire

// ===== verification/ltg_mem_model.sv
/*
 * Behavioural memory device on the far side of the guard.
 * Assumes one-cycle issue pulses and an active-low memory reset.
 */
`timescale 1ns/1ps
`default_nettype none
module ltg_mem_model #(
    parameter int INIT_NS = 95
) (
    input wire logic clk_sys,
    input wire logic mem_reset_n,
    input wire logic cke,
    input wire ltg_pkg::ltg_cmd_s cmd_issue,
    output logic [15:0] cmd_count,
    output logic fault
);
    import ltg_pkg::*;
    logic init_busy;
    // ===========================================================
    // self-timed init
    initial begin
        init_busy = 1'b0;
        cmd_count = 16'h0000;
        fault = 1'b0;
    end
    // runs on elapsed time alone, so a stopped clock cannot stall it
    always @(posedge mem_reset_n) begin
        init_busy = 1'b1;
        #(INIT_NS);
        init_busy = 1'b0;
    end
    // ===========================================================
    // fault watch
    always @(posedge clk_sys) begin
        if ((cke === 1'b1 && init_busy) || (cmd_issue.valid === 1'b1 && cke !== 1'b1)) begin
            fault <= 1'b1;
        end
        if (cmd_issue.valid === 1'b1) begin
            cmd_count <= cmd_count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ===== verification/ltg_guard_test.sv
/*
 * Self-checking bench of the command-timing guard: registers, power-up, spacing.
 * Assumes one APB wait state and a one-cycle issue pulse per taken command.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ltg_cfg.svh"
module ltg_guard_test;
    import ltg_pkg::*;
    localparam int INIT = 20;
    logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, q;
    logic pready, pslverr, mem_reset_n, cke, refresh_due, e, mfault;
    logic [2:0] b;
    logic [15:0] mcount;
    ltg_cmd_s cmd_req = '{1'b0, OP_NOP, 3'h0}, cmd_issue;
    logic [31:0] seed = 32'h0001655E;
    logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h02040904, 32'h0A040403, 32'h00060A04, 32'h030C001A};
    int err_count = 0, samples_checked = 0, cyc = 0, issued = 0;
    int t0, t_act, t_rd, t_wr, t_pre, n;
    int acts[6];
    int lim[12]; // rcd ras rp rrd wr wtr rtp faw mrr mrw wburst rfc

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    ltg_guard #(.INIT_CYCLES(INIT)) ltg_guard_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_req(cmd_req), .cmd_issue(cmd_issue), .mem_reset_n(mem_reset_n), .cke(cke), .refresh_due(refresh_due));
    ltg_mem_model #(.INIT_NS(95)) ltg_mem_model_i (.clk_sys(clk_sys), .mem_reset_n(mem_reset_n), .cke(cke),
        .cmd_issue(cmd_issue), .cmd_count(mcount), .fault(mfault));

    // ===========================================================
    // helpers
    function automatic int rnd(input int lo, input int hi);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return lo + int'(seed % 32'(hi - lo + 1));
    endfunction
    // 0 and 1 collapse onto the two-cycle acknowledge spacing
    function automatic int gap(input int v);
        return (v < 2) ? 2 : v;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_gap(input int got, input int lo, input string what);
        samples_checked++;
        if (got < lo) begin
            err_count++;
            $display("[ERR] %0t %s: %0d below %0d", $time, what, got, lo);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        while (pready !== 1'b1) @(posedge clk_sys);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // holds the request until the issue pulse is seen, then drops it
    task automatic cmd(input ltg_op_e op, input logic [2:0] bk, output int t);
        int k;
        @(posedge clk_sys);
        cmd_req <= '{1'b1, op, bk};
        for (k = 0; k < 3000 && cmd_issue.valid !== 1'b1; k++) @(posedge clk_sys);
        t = cyc;
        issued++;
        cmd_req <= '{1'b0, OP_NOP, 3'h0};
        chk({15'h0, cmd_issue.valid, cmd_issue.op, 5'h00, cmd_issue.bank}, {15'h0, 1'b1, op, 5'h00, bk}, "issued command");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ===========================================================
    // sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(q, rv[i], "reset value");
        end
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        chk(32'(e), 32'h1, "unmapped write");
        chk(32'({mem_reset_n, cke, refresh_due}), 32'h0, "outputs in reset");
        apb(1'b1, `LTG_OFS_CTRL, 32'h1);
        for (n = 0; n < 20 && mem_reset_n !== 1'b1; n++) @(posedge clk_sys);
        t0 = cyc;
        for (n = 0; n < 200 && cke !== 1'b1; n++) @(posedge clk_sys);
        chk_gap(cyc - t0, INIT, "clock enable early");
        chk_gap(INIT + 2, cyc - t0, "clock enable late");
        apb(1'b1, `LTG_OFS_STATUS, 32'h0);
        apb(1'b0, `LTG_OFS_STATUS, 32'h0);
        chk(32'(q[1:0]), 32'h3, "status after init");
        for (int it = 0; it < 3; it++) begin
            foreach (lim[j]) lim[j] = rnd(0, 20);
            apb(1'b1, `LTG_OFS_T_ACT, {8'(lim[3]), 8'(lim[2]), 8'(lim[1]), 8'(lim[0])});
            apb(1'b1, `LTG_OFS_T_RW, {8'(lim[7]), 8'(lim[6]), 8'(lim[5]), 8'(lim[4])});
            apb(1'b1, `LTG_OFS_T_MISC, {8'h00, 8'(lim[10]), 8'(lim[9]), 8'(lim[8])});
            apb(1'b1, `LTG_OFS_T_REF, {16'hFFFF, 16'(lim[11])});
            apb(1'b0, `LTG_OFS_T_RW, 32'h0);
            chk(q, {8'(lim[7]), 8'(lim[6]), 8'(lim[5]), 8'(lim[4])}, "timing readback");
            b = 3'(rnd(0, 7));
            cmd(OP_REF, b, t0);
            cmd(OP_ACT, b, t_act);
            chk_gap(t_act - t0, gap(lim[11]), "refresh busy");
            cmd(OP_RD, b, t_rd);
            chk_gap(t_rd - t_act, gap(lim[0]), "activate to read");
            cmd(OP_WR, b, t_wr);
            cmd(OP_RD, b, t_rd);
            chk_gap(t_rd - t_wr, gap(lim[5] + lim[10]), "write to read");
            cmd(OP_PRE, b, t_pre);
            chk_gap(t_pre - t_act, gap(lim[1]), "activate to precharge");
            chk_gap(t_pre - t_rd, gap(lim[6]), "read to precharge");
            chk_gap(t_pre - t_wr, gap(lim[4] + lim[10]), "write recovery");
            cmd(OP_ACT, b, acts[0]);
            chk_gap(acts[0] - t_pre, gap(lim[2]), "precharge period");
            for (int j = 1; j < 6; j++) begin
                cmd(OP_ACT, 3'(b + 3'(j)), acts[j]);
                chk_gap(acts[j] - acts[j - 1], gap(lim[3]), "activate spacing");
                if (j >= 4) chk_gap(acts[j] - acts[j - 4], lim[7], "activate window");
            end
            cmd(OP_MRR, b, t0);
            cmd(OP_PRE, b, t_pre);
            chk_gap(t_pre - t0, gap(lim[8]), "mode read spacing");
            cmd(OP_MRW, b, t0);
            cmd(OP_PRE, b, t_pre);
            chk_gap(t_pre - t0, gap(lim[9]), "mode write spacing");
        end
        apb(1'b1, `LTG_OFS_T_REF, {16'h0028, 16'h0002});
        repeat (8) cmd(OP_REF, 3'h0, t0);
        t0 = cyc;
        for (n = 0; n < 200 && refresh_due !== 1'b1; n++) @(posedge clk_sys);
        chk_gap(40 + 3, cyc - t0, "refresh owed late");
        apb(1'b0, `LTG_OFS_STATUS, 32'h0);
        chk(32'(q[2:0]), 32'h7, "status refresh owed");
        cmd(OP_REF, 3'h0, t0);
        repeat (3) @(posedge clk_sys);
        chk(32'(refresh_due), 32'h0, "refresh debt cleared");
        repeat (340) @(posedge clk_sys);
        apb(1'b0, `LTG_OFS_STATUS, 32'h0);
        chk(32'(q[11:8]), 32'(`LTG_DEBT_MAX), "refresh debt at limit");
        cmd_req <= '{1'b1, OP_ACT, 3'h1};
        repeat (6) @(posedge clk_sys);
        chk(32'(cmd_issue.valid), 32'h0, "activate taken with debt at limit");
        cmd_req <= '{1'b0, OP_NOP, 3'h0};
        chk(32'(mfault), 32'h0, "memory saw a fault");
        chk(32'(mcount), 32'(issued), "memory command count");
        tally_and_finish();
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
